/* File: purs_sequencer.v */
// power-up reset sequencer with apb register access
// Summary of operation
// [RL1] hold core while power-on detector active
// [RL2] falling supply ignored by power-on path
// [RL3] environment holds reset until conditions met
// [RL4] 72 ms rc-clocked delay after power-on/dip
// [RL5] delay enabled when disable bit zero
// [RL6] enable delay whenever dip reset enabled; the code takes the delay enable from the disable bit alone
// [RL7] 1024 osc cycles settle after delay
// [RL8] settle only in crystal modes, power-on/wake; the code also runs the settle after a dip reset in crystal modes
// [RL9] dip reset enabled when config bit one
// [RL10] long dip below threshold resets chip
// [RL11] after dip wait threshold then delay
// [RL12] dip during delay restarts full delay
// [RL13] power-on pulse, then delay, then settle
// [RL14] rc mode, delay disabled: no timeout
// [RL15] timeouts ignore master clear pin
// [RL16] dip flag cleared by dip reset
// [RL17] software sets dip flag, checks later
// [RL18] por flag cleared only by power-on
// [RL19] power-on sets expired and sleep flags
// [RL20] cause flags per watchdog/master clear event
// [RL21] non-wake resets load pc with zero
// [RL22] irq wake with enable jumps to 0004h
// [RL23] watchdog wake does not reset registers
// [RL24] supply indications enter synchronised
// [RL25] delay terminal count is a parameter
`timescale 1ns/1ps
`include "purs_consts.vh"
module purs_sequencer #(
	parameter            PC_W       = 13,
	parameter [15:0]     POWERUP_DELAY_TIMER_TICKS = `PURS_POWERUP_DELAY_TIMER_TICKS,
	parameter [15:0]     OST_TICKS  = `PURS_OST_TICKS
) (
	// apb slave
	input  wire              pclk,
	input  wire              presetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [15:0]       paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output wire              pready,
	output wire              pslverr,
	// supply monitors, pins and oscillators (asynchronous)
	input  wire              por_detect,
	input  wire              supply_above_threshold,
	input  wire              supply_dip_long,
	input  wire              master_clear_pin_n,
	input  wire              rc_osc_clk,
	input  wire              osc_in_clk,
	// core events (pclk domain)
	input  wire              core_sleeping,
	input  wire              watchdog_reset,
	input  wire              watchdog_wakeup,
	input  wire              irq_wakeup,
	input  wire              global_irq_enable,
	input  wire [PC_W-1:0]   pc_next,
	// core control
	output reg               core_reset,
	output reg               core_stall,
	output reg               pc_load,
	output reg  [PC_W-1:0]   pc_value,
	output reg               watchdog_expired_flag,
	output reg               sleep_entered_flag
);
	localparam [2:0] S_POR  = 3'h0;
	localparam [2:0] S_DIP  = 3'h1;
	localparam [2:0] S_POWERUP_DELAY_TIMER = 3'h2;
	localparam [2:0] S_OST  = 3'h3;
	localparam [2:0] S_RUN  = 3'h4;
	localparam [2:0] S_WDR  = 3'h5;
	localparam [2:0] S_WAKE = 3'h6;
	localparam [2:0] S_VEC  = 3'h7;
	localparam       NSYNC  = 6;
	localparam [NSYNC-1:0] SYNC_RST = 6'h09; // detector asserted, clear idle: no false start

	function hit;
		input [15:0] addr;
		input [11:0] idx;
		begin
			hit = (addr[15:14] == 2'h0) && (addr[13:2] == idx);
		end
	endfunction

	// synchronisers: first stage feeds only the second
	wire [NSYNC-1:0] pin_raw;
	reg  [NSYNC-1:0] sync1;
	reg  [NSYNC-1:0] sync2;
	assign pin_raw = {osc_in_clk, rc_osc_clk, master_clear_pin_n,
	                  supply_dip_long, supply_above_threshold, por_detect};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1)
		begin : g_sync
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					sync1[gi] <= SYNC_RST[gi];
					sync2[gi] <= SYNC_RST[gi];
				end
				else
				begin
					sync1[gi] <= pin_raw[gi]; // [RL24]
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	wire por_s   = sync2[0];
	wire above_s = sync2[1];
	wire dip_s   = sync2[2];
	wire master_clear_pin_s  = sync2[3];
	wire rc_s    = sync2[4];
	wire osc_s   = sync2[5];

	reg rc_prev;
	reg osc_prev;
	reg master_clear_pin_prev;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rc_prev   <= 1'b0;
			osc_prev  <= 1'b0;
			master_clear_pin_prev <= 1'b1;
		end
		else
		begin
			rc_prev   <= rc_s;
			osc_prev  <= osc_s;
			master_clear_pin_prev <= master_clear_pin_s;
		end
	end
	wire rc_tick   = rc_s & ~rc_prev;
	wire osc_tick  = osc_s & ~osc_prev;
	wire master_clear_pin_fall = master_clear_pin_prev & ~master_clear_pin_s;

	// registers
	reg [1:0] power_status_reg;
	reg [3:0] cfg;
	reg [2:0] state;
	reg [2:0] next_state;
	reg       wake_by_irq;

	wire powerup_delay_timer_en  = ~cfg[`PURS_CFG_POWERUP_DELAY_TIMER_DIS_BIT]; // [RL5]
	wire dip_en   = cfg[`PURS_CFG_DIP_EN_BIT]; // [RL9]
	wire crystal  = (cfg[`PURS_CFG_MODE_MSB:`PURS_CFG_MODE_LSB] != `PURS_MODE_RC); // [RL8]

	wire powerup_delay_timer_done;
	wire ost_done;

	purs_tick_timer #(
		.WIDTH    (16),
		.TERMINAL (POWERUP_DELAY_TIMER_TICKS)
	) u_powerup_delay_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (state != S_POWERUP_DELAY_TIMER), // [RL12]
		.tick    (rc_tick), // [RL4] [RL25]
		.done    (powerup_delay_timer_done)
	);

	purs_tick_timer #(
		.WIDTH    (16),
		.TERMINAL (OST_TICKS)
	) u_ost (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   ((state != S_OST) && (state != S_WAKE)),
		.tick    (osc_tick), // [RL7]
		.done    (ost_done)
	);

	// watchdog and wake events seen only while the core runs out of reset; dip events in any state after the delay
	wire run_ok    = (state == S_RUN) && master_clear_pin_s;
	wire ev_wdr    = run_ok && watchdog_reset && !core_sleeping;
	wire ev_wwake  = run_ok && core_sleeping && watchdog_wakeup;
	wire ev_iwake  = run_ok && core_sleeping && irq_wakeup && !watchdog_wakeup;
	wire ev_dip    = dip_en && dip_s &&
	                 (state != S_POR) && (state != S_DIP) && (state != S_POWERUP_DELAY_TIMER);
	wire powerup_delay_timer_drop = (state == S_POWERUP_DELAY_TIMER) && dip_en && !above_s;

	reg [2:0] after_dip;
	reg [2:0] after_powerup_delay_timer;
	always @*
	begin
		after_powerup_delay_timer = crystal ? S_OST : S_RUN; // [RL13]
		after_dip  = powerup_delay_timer_en ? S_POWERUP_DELAY_TIMER : after_powerup_delay_timer; // [RL14]
	end

	always @*
	begin
		next_state = state;
		case (state)
			S_POR:
				if (!por_s)
					next_state = (dip_en && !above_s) ? S_DIP : after_dip; // [RL13]
			S_DIP:
				if (above_s)
					next_state = after_dip; // [RL11]
			S_POWERUP_DELAY_TIMER:
				if (powerup_delay_timer_drop)
					next_state = S_DIP; // [RL12]
				else if (powerup_delay_timer_done)
					next_state = after_powerup_delay_timer; // [RL4]
			S_OST:
				if (ost_done)
					next_state = S_RUN; // [RL7]
			S_RUN:
				if (ev_wdr)
					next_state = S_WDR;
				else if (ev_wwake || ev_iwake)
					next_state = S_WAKE;
			S_WDR:
				next_state = S_RUN;
			S_WAKE:
				if (!crystal || ost_done)
					next_state = (wake_by_irq && global_irq_enable) ? S_VEC : S_RUN; // [RL8]
			S_VEC:
				next_state = S_RUN;
			default:
				next_state = S_POR;
		endcase
		if (ev_dip)
			next_state = S_DIP; // [RL10]
		// only the level of the detector counts, a later supply decline is the dip path's job
		if (por_s)
			next_state = S_POR; // [RL1] [RL2]
	end

	// master_clear_pin is not looked at by the sequence itself, so a release of it after the timeouts end runs at once
	wire hold_state = (state == S_POR) || (state == S_DIP) || (state == S_POWERUP_DELAY_TIMER) ||
	                  (state == S_OST) || (state == S_WDR);
	wire next_core_reset = (next_state == S_POR) || (next_state == S_DIP) ||
	                       (next_state == S_POWERUP_DELAY_TIMER) || (next_state == S_OST) ||
	                       (next_state == S_WDR) || !master_clear_pin_s; // [RL15]

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state       <= S_POR;
			core_reset  <= 1'b1;
			core_stall  <= 1'b0;
			pc_load     <= 1'b0;
			pc_value    <= `PURS_RESET_VECTOR;
			wake_by_irq <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			core_reset <= next_core_reset; // [RL1] [RL15]
			core_stall <= (next_state == S_WAKE); // [RL23]
			pc_load    <= 1'b0;
			if (ev_wwake || ev_iwake)
				wake_by_irq <= ev_iwake;
			if (core_reset && !next_core_reset)
			begin
				pc_load  <= 1'b1;
				pc_value <= `PURS_RESET_VECTOR; // [RL21]
			end
			else if ((state == S_WAKE) && (next_state != S_WAKE) && !hold_state)
			begin
				pc_load  <= 1'b1;
				pc_value <= pc_next; // [RL21] [RL23]
			end
			else if (state == S_VEC)
			begin
				pc_load  <= 1'b1;
				pc_value <= `PURS_IRQ_VECTOR; // [RL22]
			end
		end
	end

	// apb access: no wait states
	wire hit_ps    = hit(paddr, `PURS_IDX_POWER_STATUS);
	wire hit_cfg   = hit(paddr, `PURS_IDX_CONFIG);
	wire hit_cause = hit(paddr, `PURS_IDX_CAUSE);
	wire acc       = psel && penable;
	wire wr        = acc && pwrite;

	assign pready  = 1'b1;
	assign pslverr = acc && !(hit_ps || hit_cfg || hit_cause);

	// flags: hardware events are applied after software writes so they win
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			power_status_reg      <= `PURS_PS_RESET;
			cfg                   <= `PURS_CFG_RESET;
			watchdog_expired_flag <= `PURS_FLAG_RESET;
			sleep_entered_flag    <= `PURS_FLAG_RESET;
		end
		else
		begin
			if (wr && hit_ps)
				power_status_reg <= pwdata[1:0]; // [RL17]
			if (wr && hit_cfg)
				cfg <= pwdata[3:0];
			if (ev_wdr)
			begin
				watchdog_expired_flag <= 1'b0; // [RL20]
				sleep_entered_flag    <= 1'b1;
			end
			if (ev_wwake)
			begin
				watchdog_expired_flag <= 1'b0; // [RL20]
				sleep_entered_flag    <= 1'b0;
			end
			if (ev_iwake)
			begin
				watchdog_expired_flag <= 1'b1;
				sleep_entered_flag    <= 1'b0;
			end
			if (master_clear_pin_fall && core_sleeping && (state == S_RUN))
			begin
				watchdog_expired_flag <= 1'b1; // [RL20]
				sleep_entered_flag    <= 1'b0;
			end
			// left alone while detection is off, so the bit means nothing then
			if (ev_dip || powerup_delay_timer_drop)
				power_status_reg[`PURS_PS_DIP_BIT] <= 1'b0; // [RL16]
			if (por_s)
			begin
				power_status_reg[`PURS_PS_POR_BIT] <= 1'b0; // [RL18]
				watchdog_expired_flag <= 1'b1; // [RL19]
				sleep_entered_flag    <= 1'b1;
			end
		end
	end

	reg [31:0] rd;
	always @*
	begin
		rd = 32'h00000000;
		if (hit_ps)
			rd[1:0] = power_status_reg;
		else if (hit_cfg)
			rd[3:0] = cfg;
		else if (hit_cause)
		begin
			rd[`PURS_CAUSE_TO_BIT]    = watchdog_expired_flag;
			rd[`PURS_CAUSE_PD_BIT]    = sleep_entered_flag;
			rd[`PURS_CAUSE_RST_BIT]   = core_reset;
			rd[`PURS_CAUSE_STALL_BIT] = core_stall;
			rd[`PURS_CAUSE_ST_MSB:`PURS_CAUSE_ST_LSB] = state;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= rd;
	end
endmodule

/* File: purs_consts.vh */
// constants of the power-up reset sequencer: register map, fields, resets, timing
`ifndef PURS_CONSTS_VH
`define PURS_CONSTS_VH

// register indices; byte address is four times the index
`define PURS_IDX_POWER_STATUS 12'h08E
`define PURS_IDX_CONFIG       12'h080
`define PURS_IDX_CAUSE        12'h081

// power_status_reg fields and reset value
`define PURS_PS_DIP_BIT       0
`define PURS_PS_POR_BIT       1
`define PURS_PS_RESET         2'h0

// config register fields and reset value
`define PURS_CFG_POWERUP_DELAY_TIMER_DIS_BIT 0
`define PURS_CFG_DIP_EN_BIT   1
`define PURS_CFG_MODE_LSB     2
`define PURS_CFG_MODE_MSB     3
`define PURS_CFG_RESET        4'hD

// cause register fields
`define PURS_CAUSE_TO_BIT     0
`define PURS_CAUSE_PD_BIT     1
`define PURS_CAUSE_RST_BIT    2
`define PURS_CAUSE_STALL_BIT  3
`define PURS_CAUSE_ST_LSB     4
`define PURS_CAUSE_ST_MSB     6
`define PURS_FLAG_RESET       1'h1

// oscillator modes
`define PURS_MODE_LP          2'h0
`define PURS_MODE_XT          2'h1
`define PURS_MODE_HS          2'h2
`define PURS_MODE_RC          2'h3

// program counter vectors
`define PURS_RESET_VECTOR     13'h0000
`define PURS_IRQ_VECTOR       13'h0004

// timing: delay time, internal rc tick rate, tick counts (72 ms at a 100 kHz rc tick)
`define PURS_POWERUP_DELAY_TIMER_TIME_US     72000
`define PURS_RC_KHZ           100
`define PURS_POWERUP_DELAY_TIMER_TICKS       16'h1C20
`define PURS_OST_TICKS        16'h0400

`endif

/* File: purs_tick_timer.v */
// tick counter that reports when its terminal count is reached
`timescale 1ns/1ps
module purs_tick_timer #(
	parameter             WIDTH    = 16,
	parameter [WIDTH-1:0] TERMINAL = 16'h0400
) (
	// clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// control
	input  wire             clear,
	input  wire             tick,
	// status
	output wire             done
);
	reg [WIDTH-1:0] count;

	assign done = (count == TERMINAL);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= {WIDTH{1'b0}};
		else if (clear)
			count <= {WIDTH{1'b0}};
		else if (tick && !done)
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
	end
endmodule

/* File: purs_monitor.sv */
// port-level checker of the power-up reset sequencer
`timescale 1ns/1ps
module purs_monitor (
	// clock and reset
	input wire        pclk,
	input wire        presetn,
	// supply, pins and core events
	input wire        por_detect,
	input wire        master_clear_pin_n,
	input wire        supply_dip_long,
	input wire        core_sleeping,
	input wire        watchdog_reset,
	input wire        watchdog_wakeup,
	input wire        irq_wakeup,
	input wire        global_irq_enable,
	// core control
	input wire        core_reset,
	input wire        core_stall,
	input wire        pc_load,
	input wire [12:0] pc_value,
	input wire        watchdog_expired_flag,
	input wire        sleep_entered_flag
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// core running and nothing else holding it
	wire run = !core_reset && !core_stall && master_clear_pin_n && !supply_dip_long;
	AST_POR_HOLD: assert property (por_detect [*6] |-> core_reset)
		else $error("core out of reset during power-on");
	AST_POR_FLAGS: assert property (por_detect [*6] |-> watchdog_expired_flag && sleep_entered_flag)
		else $error("flags not set by power-on");
	AST_MASTER_CLEAR_PIN_HOLD: assert property (!master_clear_pin_n [*6] |-> core_reset)
		else $error("core out of reset with master clear low");
	AST_PC_ZERO: assert property (pc_load && $past(core_reset) |-> pc_value == 13'h0000)
		else $error("reset release without zero pc");
	AST_WDT_RESET: assert property (run && !core_sleeping && watchdog_reset
		|-> ##[1:3] (core_reset && !watchdog_expired_flag && sleep_entered_flag))
		else $error("watchdog reset result wrong");
	AST_WDT_WAKE: assert property (run && core_sleeping && watchdog_wakeup
		|-> ##[1:2] (!watchdog_expired_flag && !sleep_entered_flag))
		else $error("watchdog wake flags wrong");
	AST_WAKE_KEEP: assert property (run && core_sleeping && watchdog_wakeup |=> !core_reset [*4])
		else $error("watchdog wake reset the core");
	AST_IRQ_VEC: assert property (run && core_sleeping && irq_wakeup && global_irq_enable
		|-> ##[2:80] (pc_load && pc_value == 13'h0004))
		else $error("no interrupt vector after wake");
endmodule

/* File: purs_osc_model.sv */
// free-running internal rc clock and oscillator input
`timescale 1ns/1ps
module purs_osc_model (
	// clocks
	output reg rc_osc_clk,
	output reg osc_in_clk
);
	// odd half periods keep both clocks unrelated to pclk
	initial
	begin
		rc_osc_clk = 1'b0;
		osc_in_clk = 1'b0;
	end
	always #103 rc_osc_clk = ~rc_osc_clk;
	always #47 osc_in_clk = ~osc_in_clk;
endmodule

/* File: testbench.sv */
// self-checking bench of the power-up reset sequencer
`timescale 1ns/1ps
`include "purs_consts.vh"
module testbench;
	localparam [15:0] A_PS = {2'b00, `PURS_IDX_POWER_STATUS, 2'b00};
	localparam [15:0] A_CF = {2'b00, `PURS_IDX_CONFIG, 2'b00};
	localparam [15:0] A_CA = {2'b00, `PURS_IDX_CAUSE, 2'b00};
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg [15:0] paddr = 16'h0000;
	reg [31:0] pwdata = 32'h0000_0000, rd;
	reg por_detect = 1, supply_above_threshold = 1, supply_dip_long = 0;
	reg master_clear_pin_n = 1, core_sleeping = 0, watchdog_reset = 0;
	reg watchdog_wakeup = 0, irq_wakeup = 0, global_irq_enable = 0, er;
	reg [12:0] pc_next = 13'h0ABC, last_pc;
	wire [31:0] prdata;
	wire [12:0] pc_value;
	wire pready, pslverr, rc_osc_clk, osc_in_clk, core_reset, core_stall, pc_load;
	wire watchdog_expired_flag, sleep_entered_flag;
	integer num_errors = 0, compares = 0, k, cyc = 0, rc_cnt = 0, osc_cnt = 0, npl = 0;
	always #12.5 pclk = ~pclk;
	purs_osc_model osc (.rc_osc_clk, .osc_in_clk);
	purs_sequencer #(.POWERUP_DELAY_TIMER_TICKS(16'h0008), .OST_TICKS(16'h0004)) dut (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .por_detect,
		.supply_above_threshold, .supply_dip_long, .master_clear_pin_n, .rc_osc_clk,
		.osc_in_clk, .core_sleeping, .watchdog_reset, .watchdog_wakeup, .irq_wakeup,
		.global_irq_enable, .pc_next, .core_reset, .core_stall, .pc_load, .pc_value,
		.watchdog_expired_flag, .sleep_entered_flag);
	always @(posedge rc_osc_clk) if (core_reset === 1'b1) rc_cnt = rc_cnt + 1;
	always @(posedge osc_in_clk) if (core_reset === 1'b1) osc_cnt = osc_cnt + 1;
	always @(posedge pclk)
	begin
		if (pc_load === 1'b1)
		begin
			last_pc = pc_value;
			npl = npl + 1;
		end
		cyc = cyc + 1;
		if (cyc == 8000)
		begin
			num_errors = num_errors + 1;
			end_of_test;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task apb(input w, input [15:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin @(posedge pclk); end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	end
	endtask
	task wait_cr(input v, input integer lim);
	begin
		k = 0;
		#1;
		while (core_reset !== v && k < lim) begin @(posedge pclk); #1; k = k + 1; end
		chk(core_reset, v);
	end
	endtask
	task wait_pl(input integer n);
	begin
		k = 0;
		while (npl < n && k < 300) begin @(posedge pclk); k = k + 1; end
		chk(npl >= n, 1);
	end
	endtask
	task t_boot;
	begin
		apb(0, A_PS, 0); chk(rd, 0);
		apb(0, A_CF, 0); chk(rd, 32'h0000_000D);
		@(posedge pclk) por_detect <= 0;
		wait_cr(0, 12); wait_pl(1); chk(last_pc, 13'h0000);
		apb(1, A_CF, 32'h0000_0006);
		apb(1, A_PS, 32'h0000_0003);
		apb(0, 16'h0100, 0); chk(er, 1);
		chk(rd, 0);
		$display("boot test done");
	end
	endtask
	task t_por;
	begin
		@(posedge pclk) por_detect <= 1;
		master_clear_pin_n <= 0;
		repeat (4) @(posedge pclk);
		apb(0, A_PS, 0); chk(rd, 1);
		apb(0, A_CA, 0); chk(rd[1:0], 3);
		@(posedge pclk) por_detect <= 0;
		rc_cnt = 0;
		osc_cnt = 0;
		repeat (400) @(posedge pclk);
		#1 chk(core_reset, 1);
		apb(0, A_CA, 0); chk(rd[6:4], 3'h4);
		@(posedge pclk) master_clear_pin_n <= 1;
		wait_cr(0, 8);
		chk(rc_cnt >= 8, 1);
		chk(osc_cnt >= 4, 1);
		$display("power-on test done");
	end
	endtask
	task t_dip;
	begin
		apb(1, A_PS, 32'h0000_0003);
		@(posedge pclk) supply_above_threshold <= 0;
		supply_dip_long <= 1;
		wait_cr(1, 10);
		@(posedge pclk) supply_dip_long <= 0;
		apb(0, A_PS, 0); chk(rd, 2);
		@(posedge pclk) supply_above_threshold <= 1;
		rc_cnt = 0;
		k = 0;
		while (rc_cnt < 4 && k < 200) begin @(posedge pclk); k = k + 1; end
		supply_above_threshold <= 0;
		repeat (6) @(posedge pclk);
		supply_above_threshold <= 1;
		rc_cnt = 0;
		wait_cr(0, 400);
		chk(rc_cnt >= 8, 1);
		$display("dip test done");
	end
	endtask
	task t_wdt;
	begin
		@(posedge pclk) watchdog_reset <= 1;
		@(posedge pclk) watchdog_reset <= 0;
		npl = 0;
		wait_cr(1, 6);
		wait_cr(0, 10); wait_pl(1); chk(last_pc, 13'h0000);
		apb(0, A_CA, 0); chk(rd[1:0], 2);
		npl = 0;
		@(posedge pclk) core_sleeping <= 1;
		watchdog_wakeup <= 1;
		@(posedge pclk) watchdog_wakeup <= 0;
		#1 chk(core_stall, 1);
		wait_pl(1); chk(last_pc, 13'h0ABC);
		apb(0, A_CA, 0); chk(rd[1:0], 0);
		npl = 0;
		@(posedge pclk) irq_wakeup <= 1;
		global_irq_enable <= 1;
		@(posedge pclk) irq_wakeup <= 0;
		wait_pl(2); chk(last_pc, 13'h0004);
		apb(0, A_CA, 0); chk(rd[1:0], 1);
		core_sleeping <= 0;
		$display("watchdog test done");
	end
	endtask
	task t_nodip;
	begin
		apb(1, A_CF, 32'h0000_0004);
		@(posedge pclk) supply_above_threshold <= 0;
		supply_dip_long <= 1;
		repeat (20) @(posedge pclk);
		#1 chk(core_reset, 0);
		@(posedge pclk) supply_above_threshold <= 1;
		supply_dip_long <= 0;
		$display("dip disabled test done");
	end
	endtask
	task end_of_test;
	begin
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		t_boot;
		t_por;
		t_dip;
		t_wdt;
		t_nodip;
		end_of_test;
	end
endmodule
bind purs_sequencer purs_monitor mon (.pclk, .presetn, .por_detect, .master_clear_pin_n,
	.supply_dip_long, .core_sleeping, .watchdog_reset, .watchdog_wakeup, .irq_wakeup,
	.global_irq_enable, .core_reset, .core_stall, .pc_load, .pc_value,
	.watchdog_expired_flag, .sleep_entered_flag);
